// *** rtl/iecm_map.svh ***
// register offsets, field positions and reset values of the interrupt enable block
`ifndef IECM_MAP_SVH
`define IECM_MAP_SVH
`define IECM_OFF_ENABLE_BASE   12'h000
`define IECM_OFF_ENABLE_SET    12'h004
`define IECM_OFF_ENABLE_CLEAR  12'h008
`define IECM_OFF_STATUS        12'h00C
`define IECM_OFF_GATED         12'h010
`define IECM_SRC_MASK          32'h00FF_FF5F
`define IECM_RESET_VALUE       32'h0000_0000
`define IECM_READ_ZERO         32'h0000_0000
`define IECM_STC_LSB           16
`define IECM_RBW_LSB           8
`define IECM_RCV_ERR_BIT       6
`define IECM_RBR_FULL_BIT      4
`define IECM_PMT_BIT           3
`define IECM_PAT_BIT           2
`define IECM_GOP_BIT           1
`define IECM_BOUNDARY_BIT      0
`endif

// *** rtl/iecm_pkg.sv ***
// types shared by the interrupt enable block
package iecm_pkg;
  typedef logic [31:0] iecm_word_t;
endpackage : iecm_pkg

// *** rtl/iecm_top.sv ***
// interrupt enable base, set and write-only clear registers with status and interrupt gating
`timescale 1ns/1ps
`include "iecm_map.svh"

// What this block does
// - set clear bit blocks interrupt despite base enable
// - clear register reads back as zero
// - clear acts only when base and set enabled
// - write zero no change, one deactivates
// - clear bits mapped per source layout
// - clear bits reset zero, reserved bits zero
// - status records events regardless of masking
module iecm_top (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // event sources, one-cycle pulses
  input  wire logic [7:0]   timestamp_compare_evt,
  input  wire logic [7:0]   ring_buffer_write_evt,
  input  wire logic         receive_packet_error_evt,
  input  wire logic         read_buffer_full_evt,
  input  wire logic         program_map_found_evt,
  input  wire logic         program_assoc_found_evt,
  input  wire logic         picture_group_begin_evt,
  input  wire logic         boundary_found_evt,
  // interrupt
  output logic              irq
);

  iecm_pkg::iecm_word_t interrupt_enable_base_r;
  iecm_pkg::iecm_word_t interrupt_enable_set_r;
  iecm_pkg::iecm_word_t interrupt_enable_clear_r;
  iecm_pkg::iecm_word_t interrupt_status_r;
  iecm_pkg::iecm_word_t events;
  iecm_pkg::iecm_word_t armed;
  iecm_pkg::iecm_word_t gated;
  iecm_pkg::iecm_word_t prdata_nxt;
  logic                 acc;
  logic                 wr;
  logic                 rd;
  logic                 hit;

  function automatic logic is_reg(input logic [11:0] a);
    is_reg = (a == `IECM_OFF_ENABLE_BASE) || (a == `IECM_OFF_ENABLE_SET)
          || (a == `IECM_OFF_ENABLE_CLEAR) || (a == `IECM_OFF_STATUS)
          || (a == `IECM_OFF_GATED);
  endfunction : is_reg

  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign hit     = is_reg(paddr);
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;

  // source bit layout of every enable, clear and status word
  always_comb begin
    events = `IECM_READ_ZERO;
    events[`IECM_STC_LSB +: 8]    = timestamp_compare_evt;
    events[`IECM_RBW_LSB +: 8]    = ring_buffer_write_evt;
    events[`IECM_RCV_ERR_BIT]     = receive_packet_error_evt;
    events[`IECM_RBR_FULL_BIT]    = read_buffer_full_evt;
    events[`IECM_PMT_BIT]         = program_map_found_evt;
    events[`IECM_PAT_BIT]         = program_assoc_found_evt;
    events[`IECM_GOP_BIT]         = picture_group_begin_evt;
    events[`IECM_BOUNDARY_BIT]    = boundary_found_evt;
  end

  // sources enabled in both base and set registers
  assign armed = interrupt_enable_base_r & interrupt_enable_set_r;
  // a clear bit only bites on an armed source, so stale clears stay harmless
  assign gated = armed & ~(interrupt_enable_clear_r & armed);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_base_r <= `IECM_RESET_VALUE;
    end else if (wr && paddr == `IECM_OFF_ENABLE_BASE) begin
      interrupt_enable_base_r <= pwdata & `IECM_SRC_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_set_r <= `IECM_RESET_VALUE;
    end else if (wr && paddr == `IECM_OFF_ENABLE_SET) begin
      interrupt_enable_set_r <= pwdata & `IECM_SRC_MASK;
    end
  end

  // ones accumulate, zeros leave bits alone; base write re-arms nothing itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_clear_r <= `IECM_RESET_VALUE;
    end else if (wr && paddr == `IECM_OFF_ENABLE_CLEAR) begin
      interrupt_enable_clear_r <= interrupt_enable_clear_r
                                | (pwdata & `IECM_SRC_MASK & armed);
    end else if (wr && paddr == `IECM_OFF_ENABLE_SET) begin
      // writing set re-activates the sources it names
      interrupt_enable_clear_r <= interrupt_enable_clear_r & ~pwdata;
    end
  end

  // sticky status, cleared by reading it; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_status_r <= `IECM_RESET_VALUE;
    end else if (rd && paddr == `IECM_OFF_STATUS) begin
      interrupt_status_r <= events;
    end else begin
      interrupt_status_r <= interrupt_status_r | events;
    end
  end

  always_comb begin
    prdata_nxt = `IECM_READ_ZERO;
    unique case (paddr)
      `IECM_OFF_ENABLE_BASE:  prdata_nxt = interrupt_enable_base_r;
      `IECM_OFF_ENABLE_SET:   prdata_nxt = interrupt_enable_set_r;
      `IECM_OFF_ENABLE_CLEAR: prdata_nxt = `IECM_READ_ZERO;
      `IECM_OFF_STATUS:       prdata_nxt = interrupt_status_r;
      `IECM_OFF_GATED:        prdata_nxt = gated;
      default:                prdata_nxt = `IECM_READ_ZERO;
    endcase
  end

  // prdata registered in setup so it is valid in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `IECM_READ_ZERO;
    end else if (psel && !penable && !pwrite) begin
      prdata <= prdata_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(interrupt_status_r & gated);
    end
  end

  property p_clear_blocks;
    @(posedge pclk) disable iff (!presetn)
      (interrupt_enable_clear_r == interrupt_enable_base_r) |=> !irq;
  endproperty
  a_clear_blocks: assert property (p_clear_blocks) else $error("irq with all cleared");

  property p_clear_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == `IECM_OFF_ENABLE_CLEAR)
      ##1 (psel && penable) |-> prdata == `IECM_READ_ZERO;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear reg read back");

  property p_clear_needs_armed;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (interrupt_enable_clear_r & ~$past(interrupt_enable_clear_r)
                & ~$past(armed)) == `IECM_READ_ZERO;
  endproperty
  a_clear_needs_armed: assert property (p_clear_needs_armed) else $error("unarmed clear took");

  property p_write_one_sets;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `IECM_OFF_ENABLE_CLEAR)
      |=> ((($past(pwdata) & $past(armed) & `IECM_SRC_MASK) & ~interrupt_enable_clear_r) == 0)
          && ((($past(interrupt_enable_clear_r)) & ~interrupt_enable_clear_r) == 0);
  endproperty
  a_write_one_sets: assert property (p_write_one_sets) else $error("clear write wrong");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |-> (interrupt_enable_clear_r & ~`IECM_SRC_MASK) == `IECM_READ_ZERO;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved clear bit set");

  property p_status_records;
    @(posedge pclk) disable iff (!presetn)
      events[`IECM_STC_LSB] |=> interrupt_status_r[`IECM_STC_LSB];
  endproperty
  a_status_records: assert property (p_status_records) else $error("event lost");

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
      |(interrupt_status_r & gated) |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

endmodule : iecm_top

// *** test/test_iecm_top.sv ***
// self-checking bench for the interrupt enable clear block
`timescale 1ns/1ps
`include "iecm_map.svh"
module test_iecm_top;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = '0;
  logic [31:0]        pwdata = '0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [7:0]         ts = '0;
  logic [7:0]         rbw = '0;
  logic [5:0]         ev_m = '0;
  logic               irq;
  logic [32:0]        exp_q[$];
  int                 num_errors = 0;
  int                 comparisons = 0;
  int                 seed;
  iecm_pkg::iecm_word_t r;

  always #12.5 pclk = ~pclk;

  iecm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timestamp_compare_evt(ts), .ring_buffer_write_evt(rbw),
    .receive_packet_error_evt(ev_m[5]), .read_buffer_full_evt(ev_m[4]),
    .program_map_found_evt(ev_m[3]), .program_assoc_found_evt(ev_m[2]),
    .picture_group_begin_evt(ev_m[1]), .boundary_found_evt(ev_m[0]), .irq(irq));

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // reads note their expected {pslverr, prdata}; the monitor compares
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 16) begin
        num_errors++;
        conclude();
      end
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      chk("read", {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // event pulse, then irq looked at one edge after status sets
  task pulse(input logic [21:0] v, input logic e);
    {ts, rbw, ev_m} <= v;
    @(posedge pclk);
    {ts, rbw, ev_m} <= '0;
    @(posedge pclk);
    #1;
    chk("irq", {32'h0000_0000, irq}, {32'h0000_0000, e});
    @(posedge pclk);
  endtask : pulse

  initial begin
    seed = 32'hf3ec_3085;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `IECM_OFF_ENABLE_CLEAR, '0, '0);
    apb(1'b0, `IECM_OFF_GATED, '0, '0);
    apb(1'b1, `IECM_OFF_ENABLE_BASE, 32'hffff_ffff, '0);
    apb(1'b1, `IECM_OFF_ENABLE_SET, 32'hffff_ffff, '0);
    apb(1'b0, `IECM_OFF_GATED, '0, {1'b0, `IECM_SRC_MASK});
    r = $random(seed);
    apb(1'b1, `IECM_OFF_ENABLE_CLEAR, r, '0);
    apb(1'b1, `IECM_OFF_ENABLE_CLEAR, '0, '0);
    apb(1'b0, `IECM_OFF_ENABLE_CLEAR, '0, '0);
    apb(1'b0, `IECM_OFF_GATED, '0, {1'b0, `IECM_SRC_MASK & ~r});
    $display("test clear_random done");
    apb(1'b1, `IECM_OFF_ENABLE_CLEAR, 32'hffff_ffff, '0);
    pulse(22'h3f_ffff, 1'b0);
    apb(1'b0, `IECM_OFF_STATUS, '0, {1'b0, `IECM_SRC_MASK});
    apb(1'b0, `IECM_OFF_STATUS, '0, '0);
    apb(1'b1, `IECM_OFF_ENABLE_SET, 32'h0000_0001 << `IECM_BOUNDARY_BIT, '0);
    pulse(22'h00_0001, 1'b1);
    apb(1'b0, `IECM_OFF_STATUS, '0, {1'b0, 32'h0000_0001 << `IECM_BOUNDARY_BIT});
    $display("test mask_events done");
    // second reset in mid-run, then a clear while base is still off
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, `IECM_OFF_ENABLE_SET, 32'hffff_ffff, '0);
    apb(1'b1, `IECM_OFF_ENABLE_CLEAR, 32'hffff_ffff, '0);
    apb(1'b1, `IECM_OFF_ENABLE_BASE, 32'hffff_ffff, '0);
    apb(1'b0, `IECM_OFF_GATED, '0, {1'b0, `IECM_SRC_MASK});
    apb(1'b1, 12'h020, 32'hffff_ffff, '0);
    apb(1'b0, 12'h020, '0, 33'h1_0000_0000);
    $display("test ignored_clear done");
    conclude();
  end
endmodule : test_iecm_top
